// ===== ild_top.sv
// Behaviour
// RULE1: demux code delays sample take after strobe
// RULE2: code 000 no delay, 111 seven clocks
// RULE3: gated mode updates only on strobe
// RULE4: interpolated updates every clock, zero on strobe
// RULE5: rectify ones-complements negative samples
// RULE6: free run ignores interval counter
// RULE7: stop mode halts when interval expires
// RULE8: software may drop free run to read
// RULE9: leak code selects gain 1 to 2^-16
// RULE10: mode picks leaky, peak or integrator
// RULE11: leaky output is A*x plus (1-A)*y
// RULE12: software keeps free run off when integrating
// RULE13: interval holds sample count minus two
// RULE14: start write clears accumulator, restarts counter
// RULE15: interval end sets status bit 1
// RULE16: test word may feed channels or detector
// RULE17: test strobe from bit 11 or write
// RULE18: expired accumulator holds until next start
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ild_params.svh"
module ild_top #(
	parameter int ADDR_W = 18
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] sample_in,
	input wire logic input_sample_strobe,
	output logic [15:0] test_data_out,
	output logic test_strobe_out,
	output logic irq
);
	localparam int ACC_W = 48;

	logic [15:0] smp_m_q, smp_s_q;
	logic stb_m_q, stb_s_q;
	logic [31:0] cfg_q;
	logic [15:0] fmt_q, chan_q, test_word_q;
	logic done_q, mask_q, snap_done_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [ACC_W-1:0] acc_q;
	logic [16:0] remain_q;
	ild_pkg::ild_state_t state_q;
	logic test_stb_wr_q;

	logic [15:0] idx;
	logic setup, access, wr_en, rd_en, mapped, writable;
	logic start_wr, test_stb_wr;
	logic test_stb;
	logic [15:0] src_sample;
	logic src_strobe;
	logic take;
	logic [15:0] taken;
	logic interp, free, rect;
	logic [2:0] dmx;
	ild_pkg::ild_mode_t mode;
	logic [5:0] leak_sh;
	logic [15:0] x_in, x_det;
	logic upd, acc_en, done_pulse;
	logic [ACC_W-1:0] acc_d;
	logic [ACC_W:0] diff, step;

	function automatic logic [ACC_W-1:0] f_scale(input logic [15:0] x);
		f_scale = {{(ACC_W-32){x[15]}}, x, 16'h0000};
	endfunction

	function automatic logic [ACC_W-1:0] f_sext(input logic [15:0] x);
		f_sext = {{(ACC_W-16){x[15]}}, x};
	endfunction

	// Pins are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smp_m_q <= 16'h0000;
			smp_s_q <= 16'h0000;
			stb_m_q <= 1'b0;
			stb_s_q <= 1'b0;
		end else if (ce) begin
			smp_m_q <= sample_in;
			smp_s_q <= smp_m_q;
			stb_m_q <= input_sample_strobe;
			stb_s_q <= stb_m_q;
		end
	end

	// APB decode; waits while the clock enable is low
	assign idx = paddr[17:2];
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = ce;
	assign wr_en = access && pwrite && pready && mapped && writable;
	assign rd_en = access && !pwrite && pready;
	assign start_wr = wr_en && idx == `ILD_IDX_START;
	assign test_stb_wr = wr_en && idx == `ILD_IDX_TEST_STROBE;

	always_comb begin
		mapped = 1'b1;
		writable = 1'b1;
		case (idx)
			`ILD_IDX_CONFIG, `ILD_IDX_START, `ILD_IDX_TEST_WORD, `ILD_IDX_TEST_STROBE,
			`ILD_IDX_FORMAT, `ILD_IDX_CHAN, `ILD_IDX_MASK: begin
				writable = 1'b1;
			end
			`ILD_IDX_STATUS, `ILD_IDX_ACC_LO, `ILD_IDX_ACC_HI: begin
				writable = 1'b0;
			end
			default: begin
				mapped = 1'b0;
				writable = 1'b0;
			end
		endcase
	end

	// Read data captured in setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
			snap_done_q <= 1'b0;
		end else if (ce && setup) begin
			pslverr_q <= !mapped || (pwrite && !writable);
			snap_done_q <= 1'b0;
			prdata_q <= 32'h00000000;
			if (!pwrite) begin
				case (idx)
					`ILD_IDX_CONFIG: prdata_q <= cfg_q;
					`ILD_IDX_TEST_WORD: prdata_q <= {16'h0000, test_word_q};
					`ILD_IDX_FORMAT: prdata_q <= {16'h0000, fmt_q};
					`ILD_IDX_CHAN: prdata_q <= {16'h0000, chan_q};
					`ILD_IDX_MASK: prdata_q <= {30'h00000000, mask_q, 1'b0};
					`ILD_IDX_STATUS: begin
						prdata_q <= {30'h00000000, done_q, 1'b0};
						snap_done_q <= done_q;
					end
					`ILD_IDX_ACC_LO: prdata_q <= acc_q[31:0];
					`ILD_IDX_ACC_HI: prdata_q <= {16'h0000, acc_q[ACC_W-1:32]};
					default: prdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign prdata = prdata_q;
	assign pslverr = access && pslverr_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `ILD_RST_CONFIG;
			fmt_q <= `ILD_RST_16;
			chan_q <= `ILD_RST_16;
			test_word_q <= `ILD_RST_16;
			mask_q <= 1'b0;
		end else if (wr_en) begin
			case (idx)
				`ILD_IDX_CONFIG: cfg_q <= pwdata & `ILD_CFG_WMASK;
				`ILD_IDX_FORMAT: fmt_q <= pwdata[15:0] & `ILD_FMT_WMASK;
				`ILD_IDX_CHAN: chan_q <= pwdata[15:0];
				`ILD_IDX_TEST_WORD: test_word_q <= pwdata[15:0];
				`ILD_IDX_MASK: mask_q <= pwdata[`ILD_STAT_DONE];
				default: mask_q <= mask_q;
			endcase
		end
	end

	// Write strobe made one cycle long for the channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_stb_wr_q <= 1'b0;
		end else if (ce) begin
			test_stb_wr_q <= test_stb_wr;
		end
	end

	// Test word source and its strobe
	assign test_stb = chan_q[`ILD_CHAN_ENI_SEL] ? test_stb_wr_q : chan_q[`ILD_CHAN_TEST_ENI]; // [RULE17]
	assign test_data_out = chan_q[`ILD_CHAN_MIX_SRC] ? test_word_q : smp_s_q; // [RULE16]
	assign test_strobe_out = chan_q[`ILD_CHAN_MIX_SRC] ? test_stb : stb_s_q; // [RULE16]
	assign src_sample = chan_q[`ILD_CHAN_DET_SRC] ? test_word_q : smp_s_q; // [RULE16]
	assign src_strobe = chan_q[`ILD_CHAN_DET_SRC] ? test_stb : stb_s_q; // [RULE16]

	assign dmx = fmt_q[`ILD_FMT_DMX_HI:`ILD_FMT_DMX_LO];
	assign interp = fmt_q[`ILD_FMT_INTERP];
	assign free = cfg_q[`ILD_CFG_FREE];
	assign rect = cfg_q[`ILD_CFG_RECT];
	assign mode = ild_pkg::ild_mode_t'(cfg_q[`ILD_CFG_MODE_HI:`ILD_CFG_MODE_LO]); // [RULE10]

	ild_demux_delay #(
		.DATA_W(16)
	) u_dmx (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.strobe(src_strobe),
		.sample(src_sample),
		.delay(dmx),
		.take(take),
		.sample_q(taken)
	);

	always_comb begin
		case (cfg_q[`ILD_CFG_LEAK_HI:`ILD_CFG_LEAK_LO])
			2'b00: leak_sh = `ILD_LEAK_SH0; // [RULE9]
			2'b01: leak_sh = `ILD_LEAK_SH1; // [RULE9]
			2'b10: leak_sh = `ILD_LEAK_SH2; // [RULE9]
			default: leak_sh = `ILD_LEAK_SH3; // [RULE9]
		endcase
	end

	// Interpolated mode zeroes the input on strobe clocks, as specified
	// Sample used in its own take cycle; the flop only holds it between takes
	assign x_in = (interp && take) ? 16'h0000 : (take ? src_sample : taken); // [RULE4]
	assign x_det = (rect && x_in[15]) ? ~x_in : x_in; // [RULE5]
	assign upd = interp ? 1'b1 : take; // [RULE3] [RULE4]
	// Free run keeps accumulating whatever the counter does
	assign acc_en = upd && (free || state_q == ild_pkg::ILD_RUN); // [RULE6] [RULE7] [RULE18]

	// Leaky form y + A*(x - y) equals A*x + (1-A)*y without a multiplier
	assign diff = {x_det[15], f_scale(x_det)} - {acc_q[ACC_W-1], acc_q};
	assign step = $signed(diff) >>> leak_sh;

	always_comb begin
		case (mode)
			ild_pkg::ILD_LEAKY: acc_d = acc_q + step[ACC_W-1:0]; // [RULE11]
			ild_pkg::ILD_PEAK: acc_d = ($signed(f_scale(x_det)) > $signed(acc_q)) ?
				f_scale(x_det) : acc_q; // [RULE10]
			ild_pkg::ILD_INTEG: acc_d = acc_q + f_sext(x_det); // [RULE10]
			default: acc_d = acc_q;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= '0;
		end else if (ce) begin
			if (start_wr) begin
				acc_q <= '0; // [RULE14]
			end else if (acc_en) begin
				acc_q <= acc_d;
			end
		end
	end

	// Interval counter, loaded with field plus two
	assign done_pulse = ce && !start_wr && state_q == ild_pkg::ILD_RUN && upd &&
		remain_q == 17'd1; // [RULE15]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ild_pkg::ILD_IDLE;
			remain_q <= 17'd0;
		end else if (ce) begin
			if (start_wr) begin
				state_q <= ild_pkg::ILD_RUN; // [RULE14]
				remain_q <= {1'b0, cfg_q[`ILD_CFG_IVL_HI:`ILD_CFG_IVL_LO]} + `ILD_IVL_EXTRA; // [RULE13]
			end else begin
				case (state_q)
					ild_pkg::ILD_IDLE: state_q <= ild_pkg::ILD_IDLE;
					ild_pkg::ILD_RUN: begin
						if (upd) begin
							remain_q <= remain_q - 17'd1;
							if (remain_q == 17'd1) begin
								state_q <= ild_pkg::ILD_DONE; // [RULE7]
							end
						end
					end
					ild_pkg::ILD_DONE: state_q <= ild_pkg::ILD_DONE; // [RULE18]
					default: state_q <= ild_pkg::ILD_IDLE;
				endcase
			end
		end
	end

	// Sticky done; a status read clears only what it returned, new sets win
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (ce) begin
			if (done_pulse) begin
				done_q <= 1'b1; // [RULE15]
			end else if (rd_en && idx == `ILD_IDX_STATUS && snap_done_q) begin
				done_q <= 1'b0;
			end
		end
	end

	assign irq = done_q && mask_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_gated_hold;
		!interp && !take && !start_wr && ce |=> $stable(acc_q);
	endproperty
	a_gated_hold: assert property (p_gated_hold) else $error("gated mode moved without strobe"); // [RULE3]

	property p_interp_zero;
		ce && interp && take && !start_wr && acc_en && mode == ild_pkg::ILD_LEAKY &&
			leak_sh == 6'd0 |=> acc_q == '0;
	endproperty
	a_interp_zero: assert property (p_interp_zero) else $error("strobe sample not zeroed"); // [RULE4]

	property p_rectify;
		rect && x_in[15] |-> x_det == ~x_in && !x_det[15];
	endproperty
	a_rectify: assert property (p_rectify) else $error("negative sample not rectified"); // [RULE5]

	property p_free_run;
		ce && free && state_q == ild_pkg::ILD_DONE && take && !interp && !start_wr &&
			mode == ild_pkg::ILD_INTEG && x_det == 16'h0001 |=> acc_q == $past(acc_q) + 48'h1;
	endproperty
	a_free_run: assert property (p_free_run) else $error("free run stopped accumulating"); // [RULE6]

	property p_stop;
		!free && state_q != ild_pkg::ILD_RUN && !start_wr |=> $stable(acc_q);
	endproperty
	a_stop: assert property (p_stop) else $error("accumulator moved after expiry"); // [RULE7]

	property p_leak;
		ce && acc_en && !start_wr && acc_q == '0 && mode == ild_pkg::ILD_LEAKY &&
			cfg_q[19:18] == 2'b01 && x_det == 16'h0100 |=> acc_q == 48'h000000010000;
	endproperty
	a_leak: assert property (p_leak) else $error("leak gain 2^-8 wrong"); // [RULE9]

	property p_peak;
		ce && acc_en && !start_wr && mode == ild_pkg::ILD_PEAK &&
			$signed(f_scale(x_det)) > $signed(acc_q) |=> acc_q == $past(f_scale(x_det));
	endproperty
	a_peak: assert property (p_peak) else $error("peak not captured"); // [RULE10]

	property p_interval_load;
		start_wr && ce && cfg_q[15:0] == 16'h0000 |=> remain_q == 17'd2;
	endproperty
	a_interval_load: assert property (p_interval_load) else $error("interval load wrong"); // [RULE13]

	property p_start;
		start_wr && ce |=> acc_q == '0 && state_q == ild_pkg::ILD_RUN;
	endproperty
	a_start: assert property (p_start) else $error("start did not clear and restart"); // [RULE14]

	property p_done;
		done_pulse |=> done_q ##0 state_q == ild_pkg::ILD_DONE;
	endproperty
	a_done: assert property (p_done) else $error("done status not set"); // [RULE15]

	property p_test_src;
		chan_q[0] |-> src_sample == test_word_q && src_strobe == test_stb;
	endproperty
	a_test_src: assert property (p_test_src) else $error("test word not routed"); // [RULE16]

	property p_test_stb;
		chan_q[12] ? (test_stb == test_stb_wr_q) : (test_stb == chan_q[11]);
	endproperty
	a_test_stb: assert property (p_test_stb) else $error("test strobe source wrong"); // [RULE17]

	property p_expired_hold;
		state_q == ild_pkg::ILD_DONE && !start_wr |=> state_q == ild_pkg::ILD_DONE;
	endproperty
	a_expired_hold: assert property (p_expired_hold) else $error("expired state left early"); // [RULE18]

	c_done: cover property (done_pulse);
	c_peak: cover property (acc_en && mode == ild_pkg::ILD_PEAK && ce);
	c_interp: cover property (interp && take && acc_en && ce);
	c_irq: cover property (irq);
endmodule // ild_top
`default_nettype wire

// ===== ild_params.svh
`ifndef ILD_PARAMS_SVH
`define ILD_PARAMS_SVH

// Register indices; byte address is four times the index
`define ILD_IDX_CONFIG 16'hf805
`define ILD_IDX_START 16'hf806
`define ILD_IDX_TEST_WORD 16'hf807
`define ILD_IDX_TEST_STROBE 16'hf808
`define ILD_IDX_FORMAT 16'hf810
`define ILD_IDX_CHAN 16'hf811
`define ILD_IDX_STATUS 16'hf812
`define ILD_IDX_MASK 16'hf813
`define ILD_IDX_ACC_LO 16'hf814
`define ILD_IDX_ACC_HI 16'hf815

// Configuration fields
`define ILD_CFG_RECT 21
`define ILD_CFG_FREE 20
`define ILD_CFG_LEAK_HI 19
`define ILD_CFG_LEAK_LO 18
`define ILD_CFG_MODE_HI 17
`define ILD_CFG_MODE_LO 16
`define ILD_CFG_IVL_HI 15
`define ILD_CFG_IVL_LO 0
`define ILD_CFG_WMASK 32'h003fffff

// Input format fields
`define ILD_FMT_DMX_HI 6
`define ILD_FMT_DMX_LO 4
`define ILD_FMT_INTERP 3
`define ILD_FMT_WMASK 16'hfff8

// Channel control fields
`define ILD_CHAN_DET_SRC 0
`define ILD_CHAN_MIX_SRC 1
`define ILD_CHAN_TEST_ENI 11
`define ILD_CHAN_ENI_SEL 12

// Status fields
`define ILD_STAT_DONE 1

// Reset values
`define ILD_RST_CONFIG 32'h00000000
`define ILD_RST_16 16'h0000

// Leak shifts and interval offset
`define ILD_LEAK_SH0 6'd0
`define ILD_LEAK_SH1 6'd8
`define ILD_LEAK_SH2 6'd12
`define ILD_LEAK_SH3 6'd16
`define ILD_IVL_EXTRA 17'd2

`endif

// ===== ild_pkg.sv
package ild_pkg;
	typedef enum logic [1:0] {
		ILD_LEAKY,
		ILD_PEAK,
		ILD_INTEG,
		ILD_HOLD
	} ild_mode_t;

	typedef enum logic [1:0] {
		ILD_IDLE,
		ILD_RUN,
		ILD_DONE
	} ild_state_t;
endpackage

// ===== ild_demux_delay.sv
`timescale 1ns/1ps
`default_nettype none
module ild_demux_delay #(
	parameter int DATA_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic strobe,
	input wire logic [DATA_W-1:0] sample,
	input wire logic [2:0] delay,
	output logic take,
	output logic [DATA_W-1:0] sample_q
);
	logic [7:1] hist_q;
	logic [7:0] hist;

	assign hist = {hist_q, strobe};
	// Code 0 takes on the strobe itself, code 7 seven clocks later
	assign take = hist[delay]; // [RULE1] [RULE2]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_q <= 7'h00;
		end else if (ce) begin
			hist_q <= hist[6:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_q <= '0;
		end else if (ce && take) begin
			sample_q <= sample; // [RULE1]
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_zero_delay;
		strobe && delay == 3'd0 |-> take;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay take missing"); // [RULE2]

	property p_max_delay;
		(strobe && ce && delay == 3'd7) ##1 (ce && delay == 3'd7)[*7] |-> take;
	endproperty
	a_max_delay: assert property (p_max_delay) else $error("seven clock take missing"); // [RULE1]
endmodule // ild_demux_delay
`default_nettype wire

// ===== ild_sample_src.sv
`timescale 1ns/1ps
`default_nettype none
module ild_sample_src (
	input wire logic pclk,
	output logic [15:0] sample_in,
	output logic input_sample_strobe
);
	initial begin
		sample_in = 16'h0000;
		input_sample_strobe = 1'b0;
	end

	// One-clock strobe aligned with its sample
	task automatic send(input logic [15:0] v);
		@(posedge pclk);
		sample_in <= v;
		input_sample_strobe <= 1'b1;
		@(posedge pclk);
		input_sample_strobe <= 1'b0;
		// Data gone after the strobe; inverse so a late take shows
		sample_in <= ~v;
		repeat (12) @(posedge pclk);
	endtask
endmodule // ild_sample_src
`default_nettype wire

// ===== ild_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ild_params.svh"
module ild_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] sample_in;
	logic input_sample_strobe;
	logic [15:0] test_data_out;
	logic test_strobe_out;
	logic irq;
	logic [31:0] rd;
	logic er;
	int bad_count = 0;
	int n_tests = 0;

	always #4 pclk = ~pclk;

	ild_sample_src src (.pclk(pclk), .sample_in(sample_in),
		.input_sample_strobe(input_sample_strobe));

	ild_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_in(sample_in), .input_sample_strobe(input_sample_strobe),
		.test_data_out(test_data_out), .test_strobe_out(test_strobe_out), .irq(irq));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("Checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		if (k >= 64) begin
			bad_count++;
			conclude();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Any data restarts; odd value on purpose
	task automatic start(input logic [31:0] cfg);
		apb(1'b1, `ILD_IDX_CONFIG, cfg);
		apb(1'b1, `ILD_IDX_START, 32'h0000a5a5);
	endtask

	task automatic acc(input logic [31:0] exp);
		apb(1'b0, `ILD_IDX_ACC_LO, 32'h00000000);
		chk(rd, exp);
	endtask

	task automatic t_regs();
		apb(1'b0, `ILD_IDX_CONFIG, 32'h00000000);
		chk(rd, `ILD_RST_CONFIG);
		apb(1'b1, `ILD_IDX_CONFIG, 32'hffffffff);
		apb(1'b0, `ILD_IDX_CONFIG, 32'h00000000);
		chk(rd, `ILD_CFG_WMASK);
		apb(1'b1, `ILD_IDX_FORMAT, 32'h0000ffff);
		apb(1'b0, `ILD_IDX_FORMAT, 32'h00000000);
		chk(rd, {16'h0000, `ILD_FMT_WMASK});
		apb(1'b1, `ILD_IDX_FORMAT, 32'h00000000);
		apb(1'b1, 16'hf8ff, 32'h00000001);
		chk({31'h0, er}, 32'h00000001);
		apb(1'b1, `ILD_IDX_ACC_LO, 32'h00000005);
		chk({31'h0, er}, 32'h00000001);
	endtask

	task automatic t_stop();
		apb(1'b1, `ILD_IDX_MASK, 32'h00000002);
		start(32'h00020001); // Integrator, interval field 1
		repeat (5) src.send(16'h0007);
		acc(32'h00000015);
		chk({31'h0, irq}, 32'h00000001);
		apb(1'b0, `ILD_IDX_STATUS, 32'h00000000);
		chk({31'h0, rd[1]}, 32'h00000001);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h00000000);
		apb(1'b1, `ILD_IDX_START, 32'h00000000);
		acc(32'h00000000);
	endtask

	task automatic t_rect();
		start(32'h00220000);
		repeat (3) src.send(16'hfffd);
		acc(32'h00000004);
		start(32'h00020000);
		repeat (3) src.send(16'hfffd);
		acc(32'hfffffffa);
	endtask

	task automatic t_leak();
		logic [31:0] exp [4];
		exp = '{32'h01000000, 32'h00010000, 32'h00001000, 32'h00000100};
		for (int c = 0; c < 4; c++) begin
			start(32'h00100000 | (32'(c) << 18));
			src.send(16'h0100);
			acc(exp[c]);
		end
	endtask

	task automatic t_modes();
		start(32'h00100000);
		src.send(16'h0003);
		src.send(16'h0005);
		src.send(16'h0009);
		acc(32'h00090000);
		apb(1'b1, `ILD_IDX_CONFIG, 32'h00000000);
		acc(32'h00090000);
		start(32'h00000000);
		src.send(16'h0003);
		src.send(16'h0005);
		src.send(16'h0009);
		acc(32'h00050000);
		start(32'h00010001);
		src.send(16'h0005);
		src.send(16'h0009);
		src.send(16'h0002);
		acc(32'h00090000);
	endtask

	// Clock enable low freezes the pin synchronisers, so the strobe is lost
	task automatic t_ce();
		start(32'h0002000a);
		@(posedge pclk);
		ce <= 1'b0;
		src.send(16'h0007);
		ce <= 1'b1;
		acc(32'h00000000);
		src.send(16'h0007);
		acc(32'h00000007);
	endtask

	task automatic t_test();
		int cnt;
		apb(1'b1, `ILD_IDX_TEST_WORD, 32'h0000beef);
		apb(1'b1, `ILD_IDX_CHAN, 32'h00000002);
		@(posedge pclk);
		chk({16'h0000, test_data_out}, 32'h0000beef);
		apb(1'b1, `ILD_IDX_CHAN, 32'h00000802);
		@(posedge pclk);
		chk({31'h0, test_strobe_out}, 32'h00000001);
		apb(1'b1, `ILD_IDX_CHAN, 32'h00001002);
		apb(1'b1, `ILD_IDX_TEST_STROBE, 32'h00000000);
		cnt = 0;
		repeat (6) begin
			@(posedge pclk);
			if (test_strobe_out === 1'b1)
				cnt++;
		end
		chk(32'(cnt), 32'h00000001);
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_stop();
		t_rect();
		t_leak();
		t_modes();
		t_ce();
		t_test();
		conclude();
	end

	// Whole run needs well under 5000 cycles
	initial begin
		#400000;
		bad_count++;
		conclude();
	end
endmodule // ild_top_tb
`default_nettype wire
